// ==== uhcr_chk_sva.sv ====
// Port checker for the host command block
`timescale 1ns/100ps
module uhcr_chk #(
  parameter N_PORTS    = 5,
  parameter RST_CYCLES = 16
) (
  input wire               clk,
  input wire               sys_rst,
  input wire               fetch_done,
  input wire               fetch_valid,
  input wire               fetch_async,
  input wire               txn_abort,
  input wire [N_PORTS-1:0] port_bus_reset,
  input wire [N_PORTS-1:0] port_reset_req,
  input wire [N_PORTS-1:0] port_companion_r,
  input wire               halted_flag,
  input wire               periodic_en,
  input wire               async_en,
  input wire               irq_r
);
  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Counter, since the reset length is a parameter and cannot be a repetition
  reg [7:0] abort_cnt_r;
  always @(posedge clk) begin
    if (sys_rst || !txn_abort) abort_cnt_r <= 8'h00;
    else abort_cnt_r <= abort_cnt_r + 8'h01;
  end
  fetch_holds_a: assert property (
    fetch_valid && !fetch_done && !txn_abort |=> fetch_valid) else $error("fetch dropped early");
  halt_after_txn_a: assert property (
    $rose(halted_flag) |-> !$past(fetch_valid) || $past(fetch_done) || $past(txn_abort))
    else $error("halted while fetch outstanding");
  per_gate_a: assert property ($rose(fetch_valid) && !fetch_async |-> periodic_en)
    else $error("periodic fetch while disabled");
  async_gate_a: assert property (fetch_valid && fetch_async |-> async_en)
    else $error("async fetch while disabled");
  no_bus_reset_a: assert property (
    port_bus_reset == (txn_abort ? {N_PORTS{1'b0}} : port_reset_req))
    else $error("bus reset during controller reset");
  abort_txn_a: assert property (txn_abort |=> !fetch_valid)
    else $error("fetch alive during controller reset");
  ports_return_a: assert property (txn_abort |=> &port_companion_r)
    else $error("port not returned to companion");
  reset_length_a: assert property ($fell(txn_abort) |-> abort_cnt_r == RST_CYCLES)
    else $error("controller reset length wrong");
  reset_vals_a: assert property (
    $past(sys_rst) |-> halted_flag && !periodic_en && !async_en && !irq_r)
    else $error("bad state after reset");
  cover property ($rose(txn_abort));
  cover property (fetch_valid && fetch_async);
  cover property ($rose(irq_r));
endmodule // uhcr_chk

bind uhcr_top uhcr_chk #(.N_PORTS(N_PORTS), .RST_CYCLES(RST_CYCLES)) chk_i (.clk, .sys_rst,
  .fetch_done, .fetch_valid, .fetch_async, .txn_abort, .port_bus_reset, .port_reset_req,
  .port_companion_r,
  .halted_flag, .periodic_en, .async_en, .irq_r);

// ==== uhcr_regs.vh ====
// Register offsets, field positions and reset values of the host command block
`ifndef UHCR_REGS_VH
`define UHCR_REGS_VH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define UHCR_OFF_CMD        8'h20
`define UHCR_OFF_STS        8'h24
`define UHCR_OFF_MASK       8'h28
`define UHCR_OFF_FRIDX      8'h2C
`define UHCR_OFF_PLB        8'h34
`define UHCR_OFF_ALA        8'h38

// ----------------------------------------------------------------------------
// host_command fields
// ----------------------------------------------------------------------------
`define UHCR_CMD_RS         0
`define UHCR_CMD_HCRST      1
`define UHCR_CMD_FLS_LO     2
`define UHCR_CMD_FLS_HI     3
`define UHCR_CMD_PSE        4
`define UHCR_CMD_ASE        5

// Frame list size codes
`define UHCR_FLS_1024       2'h0
`define UHCR_FLS_512        2'h1
`define UHCR_FLS_256        2'h2
`define UHCR_FLS_RSVD       2'h3

// ----------------------------------------------------------------------------
// host_status and mask fields
// ----------------------------------------------------------------------------
`define UHCR_STS_HALT_EV    0
`define UHCR_STS_RDONE_EV   1
`define UHCR_STS_HALTED     12
`define UHCR_EV_W           2

// ----------------------------------------------------------------------------
// Reset values and address layout
// ----------------------------------------------------------------------------
`define UHCR_RST_FLS        2'h0
`define UHCR_RST_FRIDX      14'h0000
`define UHCR_RST_WORD       32'h0000_0000
`define UHCR_RST_EV         2'h0
`define UHCR_FRIDX_W        14
`define UHCR_IDX_LO         3
`define UHCR_IDX_HI         12
`define UHCR_MASK_1024      10'h3FF
`define UHCR_MASK_512       10'h1FF
`define UHCR_MASK_256       10'h0FF
`define UHCR_PLB_LO         12
`define UHCR_ALA_LO         5
`define UHCR_RST_CYCLES     16

`endif

// ==== uhcr_rst_seq.v ====
// Controller reset sequencer: holds the core in reset for a fixed count
`timescale 1ns/100ps
`include "uhcr_regs.vh"

module uhcr_rst_seq #(
  parameter CYCLES = `UHCR_RST_CYCLES
) (
  input  wire clk,
  input  wire sys_rst,
  input  wire start,
  output wire busy,
  output reg  done_r
);

  reg [15:0] cnt_r;
  reg        busy_r;

  assign busy = busy_r;

  always @(posedge clk) begin
    if (sys_rst) begin
      cnt_r  <= 16'h0000;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (!busy_r && start) begin
        busy_r <= 1'b1;
        cnt_r  <= CYCLES[15:0] - 16'h0001;
      end else if (busy_r) begin
        if (cnt_r == 16'h0000) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end else begin
          cnt_r <= cnt_r - 16'h0001;
        end
      end
    end
  end

endmodule // uhcr_rst_seq

// ==== uhcr_sched.v ====
// Schedule walker: run/stop handshake and list fetch requests
`timescale 1ns/100ps
`include "uhcr_regs.vh"

module uhcr_sched (
  input  wire        clk,
  input  wire        core_rst,
  input  wire        run_stop,
  input  wire        per_en,
  input  wire        async_en,
  input  wire        sof_tick,
  input  wire [9:0]  list_idx,
  input  wire [31:0] plb,
  input  wire [31:0] ala,
  input  wire        fetch_done,
  output wire        halted,
  output wire        fetch_valid,
  output reg  [31:0] fetch_addr_r,
  output reg         fetch_async_r
);

  localparam [3:0] S_HALT = 4'b0001;
  localparam [3:0] S_IDLE = 4'b0010;
  localparam [3:0] S_PER  = 4'b0100;
  localparam [3:0] S_ASY  = 4'b1000;

  reg [3:0]  state_r;
  reg [3:0]  state_nxt;

  assign halted      = state_r[0];
  assign fetch_valid = state_r[2] | state_r[3];

  always @* begin
    state_nxt = state_r;
    case (state_r)
      S_HALT: if (run_stop) state_nxt = S_IDLE;
      S_IDLE: begin
        if (!run_stop) state_nxt = S_HALT;
        else if (sof_tick && per_en) state_nxt = S_PER;
        else if (sof_tick && async_en) state_nxt = S_ASY;
      end
      S_PER: begin
        // Stop waits for the transaction in flight
        if (fetch_done) begin
          if (!run_stop) state_nxt = S_HALT;
          else if (async_en) state_nxt = S_ASY;
          else state_nxt = S_IDLE;
        end
      end
      S_ASY: if (fetch_done) state_nxt = run_stop ? S_IDLE : S_HALT;
      default: state_nxt = S_HALT;
    endcase
  end

  always @(posedge clk) begin
    if (core_rst) begin
      state_r       <= S_HALT;
      fetch_addr_r  <= `UHCR_RST_WORD;
      fetch_async_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (state_nxt == S_PER && state_r != S_PER) begin
        fetch_addr_r  <= {plb[31:`UHCR_PLB_LO], list_idx, 2'h0};
        fetch_async_r <= 1'b0;
      end else if (state_nxt == S_ASY && state_r != S_ASY) begin
        fetch_addr_r  <= {ala[31:`UHCR_ALA_LO], 5'h00};
        fetch_async_r <= 1'b1;
      end
    end
  end

endmodule // uhcr_sched

// ==== uhcr_top.v ====
// Host command register bank with status, interrupt and schedule control
//
// Summary of operation
// - Stop finishes current transaction, then halts
// - Run keeps executing schedule continuously
// - Halted flag set once truly stopped
// - Reset bit restarts internal pipelines, machines
// - Reset aborts transaction, drives no bus reset
// - Reset restores operational registers except status, and ports
// - Reset returns all ports to companions
// - Hardware clears reset bit; zero writes ignored
// - Size field picks 1024, 512, 256 entries
// - Frame index drives list position always
// - Periodic enable gates periodic list fetch
// - Async enable gates async list fetch
`timescale 1ns/100ps
`include "uhcr_regs.vh"

module uhcr_top #(
  parameter N_PORTS    = 5,
  parameter RST_CYCLES = `UHCR_RST_CYCLES
) (
  input  wire               clk,
  input  wire               sys_rst,
  input  wire [7:0]         reg_addr,
  input  wire [31:0]        reg_wdata,
  input  wire               reg_wr,
  input  wire               reg_rd,
  output reg  [31:0]        reg_rdata_r,
  input  wire               sof_tick,
  input  wire               fetch_done,
  output wire               fetch_valid,
  output wire [31:0]        fetch_addr,
  output wire               fetch_async,
  output wire               txn_abort,
  input  wire [N_PORTS-1:0] port_claim,
  input  wire [N_PORTS-1:0] port_reset_req,
  output wire [N_PORTS-1:0] port_bus_reset,
  output reg  [N_PORTS-1:0] port_companion_r,
  output wire               halted_flag,
  output wire               periodic_en,
  output wire               async_en,
  output reg                irq_r
);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  reg                     run_stop_r;
  reg  [1:0]              fls_r;
  reg                     pse_r;
  reg                     ase_r;
  reg  [`UHCR_EV_W-1:0]   sts_r;
  reg  [`UHCR_EV_W-1:0]   mask_r;
  reg  [`UHCR_FRIDX_W-1:0] fridx_r;
  reg  [31:0]             plb_r;
  reg  [31:0]             ala_r;
  reg                     halted_d_r;
  reg  [31:0]             rdata_nxt;

  wire                    wr_cmd;
  wire                    wr_sts;
  wire                    wr_mask;
  wire                    wr_fridx;
  wire                    wr_plb;
  wire                    wr_ala;
  wire                    rst_start;
  wire                    rst_busy;
  wire                    rst_done;
  wire                    core_rst;
  wire                    halted;
  wire [9:0]              list_idx;
  wire                    halt_ev;
  wire [`UHCR_EV_W-1:0]   ev_set;
  wire [`UHCR_EV_W-1:0]   ev_clr;
  wire [1:0]              cmd_fls;

  // --------------------------------------------------------------------------
  // List index mask for the selected frame list length
  // --------------------------------------------------------------------------
  function [9:0] fls_mask;
    input [1:0] fls;
    begin
      case (fls)
        `UHCR_FLS_1024: fls_mask = `UHCR_MASK_1024;
        `UHCR_FLS_512:  fls_mask = `UHCR_MASK_512;
        `UHCR_FLS_256:  fls_mask = `UHCR_MASK_256;
        default:        fls_mask = `UHCR_MASK_1024;
      endcase
    end
  endfunction

  // --------------------------------------------------------------------------
  // Register select; exact match, so aliases of a mapped offset read as unmapped
  // --------------------------------------------------------------------------
  function addr_hit;
    input [7:0] addr;
    input [7:0] off;
    begin
      addr_hit = (addr == off);
    end
  endfunction

  // --------------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------------
  assign wr_cmd   = reg_wr && addr_hit(reg_addr, `UHCR_OFF_CMD);
  assign wr_sts   = reg_wr && addr_hit(reg_addr, `UHCR_OFF_STS);
  assign wr_mask  = reg_wr && addr_hit(reg_addr, `UHCR_OFF_MASK);
  assign wr_fridx = reg_wr && addr_hit(reg_addr, `UHCR_OFF_FRIDX);
  assign wr_plb   = reg_wr && addr_hit(reg_addr, `UHCR_OFF_PLB);
  assign wr_ala   = reg_wr && addr_hit(reg_addr, `UHCR_OFF_ALA);

  // A zero write to the reset bit never reaches the sequencer
  assign rst_start = wr_cmd && reg_wdata[`UHCR_CMD_HCRST];
  assign cmd_fls   = reg_wdata[`UHCR_CMD_FLS_HI:`UHCR_CMD_FLS_LO];

  // Software-invoked reset covers every operational register except the status events
  assign core_rst = sys_rst | rst_busy;

  // --------------------------------------------------------------------------
  // Controller reset sequencer
  // --------------------------------------------------------------------------
  uhcr_rst_seq #(
    .CYCLES (RST_CYCLES)
  ) u_rst_seq (
    .clk     (clk),
    .sys_rst (sys_rst),
    .start   (rst_start),
    .busy    (rst_busy),
    .done_r  (rst_done)
  );

  // --------------------------------------------------------------------------
  // Schedule walker
  // --------------------------------------------------------------------------
  assign list_idx = fridx_r[`UHCR_IDX_HI:`UHCR_IDX_LO] & fls_mask(fls_r);

  uhcr_sched u_sched (
    .clk           (clk),
    .core_rst      (core_rst),
    .run_stop      (run_stop_r),
    .per_en        (pse_r),
    .async_en      (ase_r),
    .sof_tick      (sof_tick),
    .list_idx      (list_idx),
    .plb           (plb_r),
    .ala           (ala_r),
    .fetch_done    (fetch_done),
    .halted        (halted),
    .fetch_valid   (fetch_valid),
    .fetch_addr_r  (fetch_addr),
    .fetch_async_r (fetch_async)
  );

  assign halted_flag = halted;
  assign periodic_en = pse_r;
  assign async_en    = ase_r;

  // Abort stands for the whole sequence so no late completion slips in
  assign txn_abort = rst_busy;

  // Port reset requests are masked so a controller reset never signals on the bus
  assign port_bus_reset = port_reset_req & {N_PORTS{~rst_busy}};

  // --------------------------------------------------------------------------
  // Command register
  // --------------------------------------------------------------------------
  always @(posedge clk) begin
    if (core_rst) begin
      run_stop_r <= 1'b0;
      fls_r      <= `UHCR_RST_FLS;
      pse_r      <= 1'b0;
      ase_r      <= 1'b0;
    end else if (wr_cmd && !rst_start) begin
      // Software is trusted to raise run only while halted; no lockout here
      run_stop_r <= reg_wdata[`UHCR_CMD_RS];
      // Reserved size code is dropped so the walker never sees it
      if (cmd_fls != `UHCR_FLS_RSVD) begin
        fls_r <= cmd_fls;
      end
      pse_r <= reg_wdata[`UHCR_CMD_PSE];
      ase_r <= reg_wdata[`UHCR_CMD_ASE];
    end
  end

  // --------------------------------------------------------------------------
  // List pointers and frame index
  // --------------------------------------------------------------------------
  always @(posedge clk) begin
    if (core_rst) begin
      plb_r   <= `UHCR_RST_WORD;
      ala_r   <= `UHCR_RST_WORD;
      fridx_r <= `UHCR_RST_FRIDX;
    end else begin
      if (wr_plb) begin
        plb_r <= {reg_wdata[31:`UHCR_PLB_LO], 12'h000};
      end
      if (wr_ala) begin
        ala_r <= {reg_wdata[31:`UHCR_ALA_LO], 5'h00};
      end
      // Index is writable only while halted so a running walk stays coherent
      if (wr_fridx && halted) begin
        fridx_r <= reg_wdata[`UHCR_FRIDX_W-1:0];
      end else if (sof_tick && !halted) begin
        fridx_r <= fridx_r + 14'h0001;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Port ownership
  // --------------------------------------------------------------------------
  always @(posedge clk) begin
    if (core_rst) begin
      // Claims lose to reset, so every reset hands all ports back
      port_companion_r <= {N_PORTS{1'b1}};
    end else begin
      port_companion_r <= port_companion_r & ~port_claim;
    end
  end

  // --------------------------------------------------------------------------
  // Events, status and interrupt
  // --------------------------------------------------------------------------
  assign halt_ev = halted && !halted_d_r;
  assign ev_set  = {rst_done, halt_ev};
  assign ev_clr  = wr_sts ? reg_wdata[`UHCR_EV_W-1:0] : `UHCR_RST_EV;

  always @(posedge clk) begin
    if (core_rst) begin
      // Starts high so leaving reset never looks like a fresh halt
      halted_d_r <= 1'b1;
      mask_r     <= `UHCR_RST_EV;
      irq_r      <= 1'b0;
    end else begin
      halted_d_r <= halted;
      if (wr_mask) begin
        mask_r <= reg_wdata[`UHCR_EV_W-1:0];
      end
      irq_r <= |(sts_r & mask_r);
    end
  end

  // Status survives the controller reset so its completion event is kept
  always @(posedge clk) begin
    if (sys_rst) begin
      sts_r <= `UHCR_RST_EV;
    end else begin
      // A set in the same cycle as its clear wins
      sts_r <= (sts_r & ~ev_clr) | ev_set;
    end
  end

  // --------------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------------
  always @* begin
    rdata_nxt = `UHCR_RST_WORD;
    case (reg_addr)
      `UHCR_OFF_CMD: begin
        rdata_nxt[`UHCR_CMD_RS]    = run_stop_r;
        rdata_nxt[`UHCR_CMD_HCRST] = rst_busy;
        rdata_nxt[`UHCR_CMD_FLS_HI:`UHCR_CMD_FLS_LO] = fls_r;
        rdata_nxt[`UHCR_CMD_PSE]   = pse_r;
        rdata_nxt[`UHCR_CMD_ASE]   = ase_r;
      end
      `UHCR_OFF_STS: begin
        rdata_nxt[`UHCR_EV_W-1:0]     = sts_r;
        rdata_nxt[`UHCR_STS_HALTED]   = halted;
      end
      `UHCR_OFF_MASK: begin
        rdata_nxt[`UHCR_EV_W-1:0] = mask_r;
      end
      `UHCR_OFF_FRIDX: begin
        rdata_nxt[`UHCR_FRIDX_W-1:0] = fridx_r;
      end
      `UHCR_OFF_PLB: begin
        rdata_nxt = plb_r;
      end
      `UHCR_OFF_ALA: begin
        rdata_nxt = ala_r;
      end
      default: begin
        rdata_nxt = `UHCR_RST_WORD;
      end
    endcase
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata_r <= `UHCR_RST_WORD;
    end else if (reg_rd) begin
      reg_rdata_r <= rdata_nxt;
    end else begin
      reg_rdata_r <= `UHCR_RST_WORD;
    end
  end

endmodule // uhcr_top

// ==== uhcr_top_tb.sv ====
// Self-checking bench for the host command block
`timescale 1ns/100ps
module uhcr_top_tb;
  logic        clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        sof_tick = 1'b0, fetch_done = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata_r, fetch_addr, d;
  logic [4:0]  port_claim = 5'h00, port_reset_req = 5'h00, port_bus_reset, port_companion_r;
  logic        fetch_valid, fetch_async, txn_abort, halted_flag, periodic_en, async_en, irq_r;
  logic [9:0]  msk [3] = '{10'h3FF, 10'h1FF, 10'h0FF};
  int          n_mismatch = 0, samples_checked = 0;
  // Short reset sequence keeps the run brief; still long enough to poll mid-way
  uhcr_top #(.N_PORTS(5), .RST_CYCLES(8)) uut (.clk, .sys_rst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata_r, .sof_tick, .fetch_done, .fetch_valid, .fetch_addr,
    .fetch_async, .txn_abort, .port_claim, .port_reset_req, .port_bus_reset,
    .port_companion_r, .halted_flag, .periodic_en, .async_en, .irq_r);
  always #2.5 clk = ~clk;
  // --------------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("Counts: %0d checked, %0d mismatches", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata_r, exp);
  endtask
  task automatic pulse(input int s);
    @(posedge clk);
    if (s == 0) sof_tick <= 1'b1;
    else fetch_done <= 1'b1;
    @(posedge clk);
    sof_tick <= 1'b0;
    fetch_done <= 1'b0;
  endtask
  // Selector: 0 fetch, 1 halted, 2 reset busy, 3 async fetch
  task automatic wait_on(input int s, input logic lvl);
    logic v;
    for (int i = 0; i < 200; i++) begin
      @(posedge clk);
      #1 v = (s == 0) ? fetch_valid : (s == 1) ? halted_flag :
             (s == 2) ? txn_abort : (fetch_valid && fetch_async);
      if (v === lvl) return;
    end
    n_mismatch++;
    $display("Error at %0t: wait timed out", $time);
    end_of_test();
  endtask
  // --------------------------------------------------------------------------
  // Sequence
  // --------------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    rdc(8'h20, 32'h0000_0000);
    rdc(8'h24, 32'h0000_1000);
    rdc(8'h10, 32'h0000_0000);
    wr(8'h20, 32'h0000_0008);
    rdc(8'h20, 32'h0000_0008);
    wr(8'h20, 32'h0000_000C);
    rdc(8'h20, 32'h0000_0008);
    $display("Reset values and size field test done");
    // Index low bits stay below 8 so list position is fixed over the ticks
    wr(8'h2C, 32'h0000_1D50);
    wr(8'h34, 32'hABCD_E123);
    wr(8'h38, 32'h1234_5678);
    for (int f = 0; f < 3; f++) begin
      wr(8'h20, 32'h0000_0010 | (f << 2));
      wr(8'h20, 32'h0000_0011 | (f << 2));
      pulse(0);
      wait_on(0, 1'b1);
      chk(fetch_addr, {20'hABCDE, 10'h3AA & msk[f], 2'b00});
      chk({31'h0, fetch_async}, 32'h0000_0000);
      pulse(1);
      wait_on(0, 1'b0);
      wr(8'h20, 32'h0000_0010 | (f << 2));
      wait_on(1, 1'b1);
    end
    $display("Periodic fetch test done");
    wr(8'h28, 32'h0000_0003);
    wr(8'h24, 32'h0000_0003);
    wr(8'h20, 32'h0000_0038);
    wr(8'h20, 32'h0000_0039);
    pulse(0);
    wait_on(0, 1'b1);
    chk(fetch_addr, 32'hABCD_E2A8);
    pulse(1);
    wait_on(3, 1'b1);
    chk(fetch_addr, 32'h1234_5660);
    wr(8'h20, 32'h0000_0038);
    repeat (3) @(posedge clk);
    #1 chk({31'h0, halted_flag}, 32'h0000_0000);
    pulse(1);
    wait_on(1, 1'b1);
    repeat (3) @(posedge clk);
    #1 chk({31'h0, irq_r}, 32'h0000_0001);
    rdc(8'h24, 32'h0000_1001);
    wr(8'h24, 32'h0000_0001);
    repeat (3) @(posedge clk);
    #1 chk({31'h0, irq_r}, 32'h0000_0000);
    // Async schedule alone: the walker returns to idle and keeps running
    wr(8'h20, 32'h0000_0020);
    wr(8'h20, 32'h0000_0021);
    pulse(0);
    wait_on(3, 1'b1);
    chk(fetch_addr, 32'h1234_5660);
    pulse(1);
    wait_on(0, 1'b0);
    chk({31'h0, halted_flag}, 32'h0000_0000);
    wr(8'h20, 32'h0000_0020);
    wait_on(1, 1'b1);
    wr(8'h24, 32'h0000_0001);
    $display("Async fetch and stop test done");
    @(posedge clk);
    port_claim <= 5'h1F;
    port_reset_req <= 5'h1F;
    @(posedge clk);
    port_claim <= 5'h00;
    @(posedge clk);
    #1 chk({27'h0, port_companion_r}, 32'h0000_0000);
    wr(8'h20, 32'h0000_0014);
    wr(8'h20, 32'h0000_0002);
    rdc(8'h20, 32'h0000_0002);
    wr(8'h20, 32'h0000_0000);
    rdc(8'h20, 32'h0000_0002);
    chk({27'h0, port_bus_reset}, 32'h0000_0000);
    wait_on(2, 1'b0);
    rdc(8'h20, 32'h0000_0000);
    rdc(8'h2C, 32'h0000_0000);
    rdc(8'h34, 32'h0000_0000);
    rdc(8'h28, 32'h0000_0000);
    rdc(8'h24, 32'h0000_1002);
    chk({27'h0, port_companion_r}, 32'h0000_001F);
    chk({27'h0, port_bus_reset}, 32'h0000_001F);
    chk({31'h0, irq_r}, 32'h0000_0000);
    $display("Controller reset test done");
    end_of_test();
  end
endmodule // uhcr_top_tb
